// ---- hw/sbsc_top.sv ----
`include "sbsc_params.svh"
`timescale 1ns/100ps
`default_nettype none
module sbsc_top
	import sbsc_pkg::*;
(
	input  wire logic        mclk,      // 25 MHz clock
	input  wire logic        rst_n,     // sync reset, active low
	input  wire logic        ce,        // clock enable
	input  wire logic        psel,      // apb select
	input  wire logic        penable,   // apb enable
	input  wire logic        pwrite,    // apb direction
	input  wire logic [11:0] paddr,     // apb byte address
	input  wire logic [31:0] pwdata,    // apb write data
	output logic      [31:0] prdata,    // apb read data
	output logic             pready,    // apb ready
	output logic             pslverr,   // apb error
	input  wire logic        trig_in,   // rear trigger input
	output logic             sample_wr, // record one sample now
	output logic      [13:0] sample_bin,// bin being written
	output logic             buf_clear, // discard both channel buffers
	output logic             alarm,     // audible alarm request
	output logic             irq        // level interrupt
);
	sbsc_state_s s_reg;
	sbsc_state_s s_next;
	sbsc_sample_s smp;
	logic        wr_acc;
	logic        rd_acc;
	logic        fire;
	logic        start_ev;
	logic        take;
	logic        cmd_start;
	logic        cmd_hold;
	logic        cmd_clear;
	logic        mapped;
	logic [31:0] rd_val;
	logic [31:0] period;

	// =====================================================
	// helpers
	function automatic logic [31:0] rate_period(input logic [3:0] code);
		logic [31:0] p;
		p = 32'(`SBSC_FAST_CYCLES);
		return p << (4'(`SBSC_RATE_MAX) - code);
	endfunction

	function automatic logic is_off(input logic [11:0] a, input logic [11:0] o);
		return a == o;
	endfunction

	// =====================================================
	// bus decode
	assign pready  = 1'b1;
	assign wr_acc  = ce & psel & penable & pwrite;
	// read data is loaded in the setup cycle so it stands at the access edge
	assign rd_acc  = ce & psel & ~penable & ~pwrite;
	assign mapped  = is_off(paddr, `SBSC_OFF_CTRL) | is_off(paddr, `SBSC_OFF_CMD) |
		is_off(paddr, `SBSC_OFF_STATUS) | is_off(paddr, `SBSC_OFF_POINTS) |
		is_off(paddr, `SBSC_OFF_WPTR) | is_off(paddr, `SBSC_OFF_IRQ_ST) |
		is_off(paddr, `SBSC_OFF_IRQ_MSK);
	assign pslverr = psel & penable & ~mapped;
	assign cmd_start = wr_acc & is_off(paddr, `SBSC_OFF_CMD) & pwdata[`SBSC_CMD_START];
	assign cmd_hold  = wr_acc & is_off(paddr, `SBSC_OFF_CMD) & pwdata[`SBSC_CMD_HOLD];
	assign cmd_clear = wr_acc & is_off(paddr, `SBSC_OFF_CMD) & pwdata[`SBSC_CMD_CLEAR];
	// software fire joins the rear edge before anything looks at it
	assign fire = (trig_in & ~s_reg.trig_d) |
		(wr_acc & is_off(paddr, `SBSC_OFF_CMD) & pwdata[`SBSC_CMD_FIRE]);
	assign period = rate_period(s_reg.rate);

	always_comb begin
		rd_val = 32'h0;
		if (is_off(paddr, `SBSC_OFF_CTRL)) begin
			rd_val = {26'h0, s_reg.arm, s_reg.loop, s_reg.rate};
		end else if (is_off(paddr, `SBSC_OFF_STATUS)) begin
			rd_val = {28'h0, s_reg.wrapped, s_reg.alarm, s_reg.mode};
		end else if (is_off(paddr, `SBSC_OFF_POINTS)) begin
			rd_val = {18'h0, s_reg.points};
		end else if (is_off(paddr, `SBSC_OFF_WPTR)) begin
			rd_val = {18'h0, s_reg.wptr};
		end else if (is_off(paddr, `SBSC_OFF_IRQ_ST)) begin
			rd_val = {29'h0, s_reg.irq_st};
		end else if (is_off(paddr, `SBSC_OFF_IRQ_MSK)) begin
			rd_val = {29'h0, s_reg.irq_msk};
		end
	end

	// =====================================================
	// scan control
	always_comb begin
		s_next   = s_reg;
		smp      = '0;
		start_ev = cmd_start | (s_reg.arm & fire & s_reg.mode != SBSC_RUN);
		take     = 1'b0;
		if (ce) begin
			s_next.trig_d = trig_in;
			if (rd_acc) begin
				s_next.prdata = rd_val;
			end
			if (wr_acc & is_off(paddr, `SBSC_OFF_CTRL)) begin
				if (pwdata[`SBSC_CTRL_RATE_HI:`SBSC_CTRL_RATE_LO] <= `SBSC_RATE_TRIGGER) begin
					s_next.rate = pwdata[`SBSC_CTRL_RATE_HI:`SBSC_CTRL_RATE_LO];
				end
				s_next.loop = pwdata[`SBSC_CTRL_LOOP];
				s_next.arm  = pwdata[`SBSC_CTRL_ARM];
			end
			if (wr_acc & is_off(paddr, `SBSC_OFF_IRQ_MSK)) begin
				s_next.irq_msk = pwdata[2:0];
			end
			if (wr_acc & is_off(paddr, `SBSC_OFF_IRQ_ST)) begin
				s_next.irq_st = s_reg.irq_st & ~pwdata[2:0];
			end
			if (s_reg.holdoff != 32'h0) begin
				s_next.holdoff = s_reg.holdoff - 32'h1;
			end
			if (s_reg.tick_cnt != 32'h0) begin
				s_next.tick_cnt = s_reg.tick_cnt - 32'h1;
			end
			unique case (s_reg.mode)
				SBSC_IDLE, SBSC_PAUSE, SBSC_DONE: begin
					if (start_ev & s_reg.mode != SBSC_DONE) begin
						s_next.mode     = SBSC_RUN;
						s_next.tick_cnt = period - 32'h1;
						s_next.holdoff  = 32'(`SBSC_FAST_CYCLES) - 32'h1;
					end
				end
				SBSC_RUN: begin
					if (cmd_hold) begin
						s_next.mode = SBSC_PAUSE;
					end else if (s_reg.rate == `SBSC_RATE_TRIGGER) begin
						take = fire & (s_reg.holdoff == 32'h0);
					end else begin
						take = s_reg.tick_cnt == 32'h0;
					end
				end
			endcase
			if (take) begin
				smp.valid = 1'b1;
				smp.bin   = s_reg.wptr;
				s_next.tick_cnt = period - 32'h1;
				s_next.holdoff  = 32'(`SBSC_FAST_CYCLES) - 32'h1;
				if (s_reg.points != `SBSC_DEPTH) begin
					s_next.points = s_reg.points + 14'h1;
				end
				if (s_reg.wptr == `SBSC_DEPTH - 14'h1) begin
					s_next.wptr = 14'h0;
					if (s_reg.loop) begin
						s_next.wrapped = 1'b1;
					end else begin
						s_next.mode  = SBSC_DONE;
						s_next.alarm = 1'b1;
					end
				end else begin
					s_next.wptr = s_reg.wptr + 14'h1;
				end
			end
			// events set over a clear in the same cycle
			s_next.irq_st = s_next.irq_st | {fire, take & ~s_reg.loop &
				(s_reg.wptr == `SBSC_DEPTH - 14'h1), take};
			if (cmd_clear) begin
				s_next.mode     = SBSC_IDLE;
				s_next.wptr     = 14'h0;
				s_next.points   = 14'h0;
				s_next.wrapped  = 1'b0;
				s_next.alarm    = 1'b0;
				s_next.tick_cnt = 32'h0;
				smp             = '0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_reg      <= '0;
			s_reg.loop <= 1'(`SBSC_CTRL_RESET >> `SBSC_CTRL_LOOP);
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata     = s_reg.prdata;
	assign sample_wr  = smp.valid;
	assign sample_bin = smp.bin;
	assign buf_clear  = cmd_clear;
	assign alarm      = s_reg.alarm;
	assign irq        = |(s_reg.irq_st & s_reg.irq_msk);

	// =====================================================
	// checks
	property p_clear;
		@(posedge mclk) disable iff (!rst_n) cmd_clear |=> s_reg.mode == SBSC_IDLE && s_reg.points == 14'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not reset");
	property p_start_run;
		@(posedge mclk) disable iff (!rst_n)
		(ce && cmd_start && !cmd_clear && (s_reg.mode == SBSC_IDLE || s_reg.mode == SBSC_PAUSE))
		|=> s_reg.mode == SBSC_RUN;
	endproperty
	a_start_run: assert property (p_start_run) else $error("start ignored");
	property p_hold;
		@(posedge mclk) disable iff (!rst_n)
		(ce && cmd_hold && !cmd_clear && s_reg.mode == SBSC_RUN) |=> s_reg.mode == SBSC_PAUSE;
	endproperty
	a_hold: assert property (p_hold) else $error("hold failed");
	property p_hold_idle;
		@(posedge mclk) disable iff (!rst_n)
		(cmd_hold && !cmd_start && s_reg.mode == SBSC_IDLE) |=> s_reg.mode == SBSC_IDLE;
	endproperty
	a_hold_idle: assert property (p_hold_idle) else $error("hold left idle");
	property p_no_sample_idle;
		@(posedge mclk) disable iff (!rst_n) s_reg.mode != SBSC_RUN |-> !sample_wr;
	endproperty
	a_no_sample_idle: assert property (p_no_sample_idle) else $error("sample outside run");
	property p_wrap;
		@(posedge mclk) disable iff (!rst_n)
		(sample_wr && s_reg.loop && sample_bin == 14'h3FFE && !cmd_clear) |=> s_reg.wptr == 14'h0 && s_reg.wrapped;
	endproperty
	a_wrap: assert property (p_wrap) else $error("loop did not wrap");
	property p_full_stop;
		@(posedge mclk) disable iff (!rst_n)
		(sample_wr && !s_reg.loop && sample_bin == 14'h3FFE && !cmd_clear) |=> s_reg.mode == SBSC_DONE && alarm;
	endproperty
	a_full_stop: assert property (p_full_stop) else $error("single shot did not stop");
	property p_trig_gap;
		@(posedge mclk) disable iff (!rst_n)
		(sample_wr && s_reg.rate == 4'hE) |=> !sample_wr [*8];
	endproperty
	a_trig_gap: assert property (p_trig_gap) else $error("trigger too fast accepted");
	property p_arm_start;
		@(posedge mclk) disable iff (!rst_n)
		(ce && fire && s_reg.arm && s_reg.mode == SBSC_IDLE && !cmd_clear) |=> s_reg.mode == SBSC_RUN;
	endproperty
	a_arm_start: assert property (p_arm_start) else $error("armed trigger no start");
	property p_irq;
		@(posedge mclk) disable iff (!rst_n) irq |-> $past(rst_n) && (|s_reg.irq_msk);
	endproperty
	a_irq: assert property (p_irq) else $error("irq without mask");

	property p_fire_irq;
		@(posedge mclk) disable iff (!rst_n)
		(ce && fire)
		|=> s_reg.irq_st[`SBSC_IRQ_TRIG];
	endproperty
	a_fire_irq: assert property (p_fire_irq) else $error("fire event not flagged");

	property p_rate_refuse;
		@(posedge mclk) disable iff (!rst_n)
		(wr_acc && is_off(paddr, `SBSC_OFF_CTRL) && pwdata[3:0] == 4'hF)
		|=> s_reg.rate == $past(s_reg.rate);
	endproperty
	a_rate_refuse: assert property (p_rate_refuse) else $error("rate 15 accepted");

	property p_loop_wr;
		@(posedge mclk) disable iff (!rst_n)
		(wr_acc && is_off(paddr, `SBSC_OFF_CTRL))
		|=> s_reg.loop == $past(pwdata[`SBSC_CTRL_LOOP]);
	endproperty
	a_loop_wr: assert property (p_loop_wr) else $error("end mode not stored");

	property p_arm_wr;
		@(posedge mclk) disable iff (!rst_n)
		(wr_acc && is_off(paddr, `SBSC_OFF_CTRL))
		|=> s_reg.arm == $past(pwdata[`SBSC_CTRL_ARM]);
	endproperty
	a_arm_wr: assert property (p_arm_wr) else $error("arm setting not stored");

	property p_start_ignored;
		@(posedge mclk) disable iff (!rst_n)
		(ce && cmd_start && !cmd_hold && !cmd_clear && !sample_wr && s_reg.mode == SBSC_RUN)
		|=> s_reg.mode == SBSC_RUN;
	endproperty
	a_start_ignored: assert property (p_start_ignored) else $error("start disturbed run");

	property p_pause_keep;
		@(posedge mclk) disable iff (!rst_n)
		(ce && cmd_hold && !cmd_start && !cmd_clear && s_reg.mode == SBSC_PAUSE)
		|=> s_reg.mode == SBSC_PAUSE;
	endproperty
	a_pause_keep: assert property (p_pause_keep) else $error("hold left pause");

	property p_clear_out;
		@(posedge mclk) disable iff (!rst_n)
		cmd_clear
		|-> buf_clear && !sample_wr;
	endproperty
	a_clear_out: assert property (p_clear_out) else $error("clear pulse wrong");

	property p_holdoff;
		@(posedge mclk) disable iff (!rst_n)
		(ce && fire && s_reg.rate == `SBSC_RATE_TRIGGER && s_reg.holdoff != 32'h0)
		|-> !sample_wr;
	endproperty
	a_holdoff: assert property (p_holdoff) else $error("fast trigger sampled");

	property p_trig_take;
		@(posedge mclk) disable iff (!rst_n)
		(ce && fire && s_reg.mode == SBSC_RUN && s_reg.rate == `SBSC_RATE_TRIGGER &&
			s_reg.holdoff == 32'h0 && !cmd_hold && !cmd_clear)
		|-> sample_wr;
	endproperty
	a_trig_take: assert property (p_trig_take) else $error("trigger not sampled");

	property p_done_keep;
		@(posedge mclk) disable iff (!rst_n)
		(s_reg.mode == SBSC_DONE && !cmd_clear)
		|=> s_reg.mode == SBSC_DONE && alarm;
	endproperty
	a_done_keep: assert property (p_done_keep) else $error("done state left");

	property p_bin_range;
		@(posedge mclk) disable iff (!rst_n)
		sample_wr
		|-> sample_bin <= `SBSC_DEPTH - 14'h1;
	endproperty
	a_bin_range: assert property (p_bin_range) else $error("bin out of range");

	c_trig_sample: cover property (@(posedge mclk) sample_wr && s_reg.rate == `SBSC_RATE_TRIGGER);
	c_clear: cover property (@(posedge mclk) cmd_clear && s_reg.mode == SBSC_RUN);
	c_wrap: cover property (@(posedge mclk) s_reg.wrapped);
	c_done: cover property (@(posedge mclk) s_reg.mode == SBSC_DONE);
endmodule // sbsc_top
`default_nettype wire

// ---- include/sbsc_params.svh ----
`ifndef SBSC_PARAMS_SVH
`define SBSC_PARAMS_SVH
// register byte offsets
`define SBSC_OFF_CTRL    12'h000
`define SBSC_OFF_CMD     12'h004
`define SBSC_OFF_STATUS  12'h008
`define SBSC_OFF_POINTS  12'h00C
`define SBSC_OFF_WPTR    12'h010
`define SBSC_OFF_IRQ_ST  12'h014
`define SBSC_OFF_IRQ_MSK 12'h018
// control fields
`define SBSC_CTRL_RATE_LO 0
`define SBSC_CTRL_RATE_HI 3
`define SBSC_CTRL_LOOP    4
`define SBSC_CTRL_ARM     5
// command bits
`define SBSC_CMD_START 0
`define SBSC_CMD_HOLD  1
`define SBSC_CMD_CLEAR 2
`define SBSC_CMD_FIRE  3
// interrupt bits
`define SBSC_IRQ_SAMPLE 0
`define SBSC_IRQ_FULL   1
`define SBSC_IRQ_TRIG   2
// reset values: loop mode, rate code 0, arm off
`define SBSC_CTRL_RESET 6'h10
`define SBSC_RATE_TRIGGER 4'hE
`define SBSC_RATE_MAX     4'hD
`define SBSC_DEPTH        14'h3FFF
// timing: clock 25 MHz; slowest rate 62.5 mHz = 16 s period
`define SBSC_CLK_HZ        25000000
`define SBSC_FAST_HZ       512
`define SBSC_FAST_CYCLES   (`SBSC_CLK_HZ / `SBSC_FAST_HZ)
`define SBSC_TRIG_LAT_MS   2
`define SBSC_TRIG_LAT_CYC  ((`SBSC_CLK_HZ / 1000) * `SBSC_TRIG_LAT_MS)
`endif

// ---- include/sbsc_pkg.sv ----
package sbsc_pkg;
	typedef enum logic [1:0] {
		SBSC_IDLE,
		SBSC_RUN,
		SBSC_PAUSE,
		SBSC_DONE
	} sbsc_mode_e;
	typedef struct packed {
		sbsc_mode_e  mode;
		logic [3:0]  rate;
		logic        loop;
		logic        arm;
		logic [13:0] wptr;
		logic [13:0] points;
		logic        wrapped;
		logic [31:0] tick_cnt;
		logic [31:0] holdoff;
		logic        trig_d;
		logic [2:0]  irq_st;
		logic [2:0]  irq_msk;
		logic        alarm;
		logic [31:0] prdata;
	} sbsc_state_s;
	typedef struct packed {
		logic        valid;
		logic [13:0] bin;
	} sbsc_sample_s;
endpackage

// ---- verification/sbsc_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// host side: apb master and rear trigger source
module sbsc_host_model
	import sbsc_pkg::*;
(
	input  wire logic        mclk,    // clock
	output logic             psel,    // apb select
	output logic             penable, // apb enable
	output logic             pwrite,  // apb direction
	output logic      [11:0] paddr,   // apb byte address
	output logic      [31:0] pwdata,  // apb write data
	input  wire logic [31:0] prdata,  // apb read data
	input  wire logic        pready,  // apb ready
	input  wire logic        pslverr, // apb error
	output logic             trig_in  // rear trigger, idle low
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		trig_in = 1'b0;
	end
	// read data stands registered during the access phase
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		err = pslverr;
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			sample_buffer_scan_control_tb.errors++;
			sample_buffer_scan_control_tb.summarize();
		end
	endtask
	task automatic trig();
		@(posedge mclk);
		trig_in <= 1'b1;
		repeat (2) @(posedge mclk);
		trig_in <= 1'b0;
	endtask
endmodule // sbsc_host_model
`default_nettype wire

// ---- verification/sample_buffer_scan_control_tb.sv ----
`include "sbsc_params.svh"
`timescale 1ns/100ps
`default_nettype none
module sample_buffer_scan_control_tb
	import sbsc_pkg::*;
;
	logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, trig_in;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic        sample_wr, buf_clear, alarm, irq, rerr, clr_seen;
	logic [13:0] sample_bin, last_bin;
	int          errors, cmp_count, nsamp;
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	sbsc_host_model sbsc_host_model_inst (.mclk(mclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .trig_in(trig_in));
	sbsc_top sbsc_top_inst (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .trig_in(trig_in), .sample_wr(sample_wr),
		.sample_bin(sample_bin), .buf_clear(buf_clear), .alarm(alarm), .irq(irq));
	// ==================================================
	// monitor of recorded samples and buffer clears
	initial begin
		nsamp = 0;
		last_bin = 14'h0000;
		clr_seen = 1'b0;
	end
	always @(posedge mclk) begin
		if (sample_wr === 1'b1) begin
			nsamp <= nsamp + 1;
			last_bin <= sample_bin;
		end
		if (buf_clear === 1'b1) clr_seen <= 1'b1;
	end
	// ==================================================
	// access and compare tasks
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		sbsc_host_model_inst.xfer(1'b1, a, d, rdata, rerr);
	endtask
	task automatic rd(input logic [11:0] a);
		sbsc_host_model_inst.xfer(1'b0, a, 32'h00000000, rdata, rerr);
	endtask
	task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		chk32(nm, {31'h0, e}, {31'h0, g});
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ==================================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		errors = 0;
		cmp_count = 0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rd(`SBSC_OFF_CTRL); chk32("ctrl reset", 32'h10, rdata);
		rd(`SBSC_OFF_STATUS); chk32("status reset", {30'h0, SBSC_IDLE}, rdata);
		$display("test reset done");
		for (int i = 0; i < 15; i++) begin
			wr(`SBSC_OFF_CTRL, 32'h20 | i);
			rd(`SBSC_OFF_CTRL); chk32("ctrl rate", 32'h20 | i, rdata);
		end
		wr(`SBSC_OFF_CTRL, 32'h2F);
		rd(`SBSC_OFF_CTRL); chk32("rate 15", 32'h2E, rdata);
		wr(`SBSC_OFF_CMD, 32'h2);
		rd(`SBSC_OFF_STATUS); chk32("hold idle", {30'h0, SBSC_IDLE}, rdata);
		$display("test settings done");
		sbsc_host_model_inst.trig();
		rd(`SBSC_OFF_STATUS); chk32("armed start", {30'h0, SBSC_RUN}, rdata);
		rd(`SBSC_OFF_POINTS); chk32("points start", 32'h0, rdata);
		sbsc_host_model_inst.trig();
		rd(`SBSC_OFF_POINTS); chk32("trig in holdoff", 32'h0, rdata);
		repeat (48850) @(posedge mclk);
		sbsc_host_model_inst.trig();
		rd(`SBSC_OFF_POINTS); chk32("points trig", 32'h1, rdata);
		wr(`SBSC_OFF_CMD, 32'h8);
		rd(`SBSC_OFF_POINTS); chk32("fast fire", 32'h1, rdata);
		repeat (48850) @(posedge mclk);
		wr(`SBSC_OFF_CMD, 32'h8);
		rd(`SBSC_OFF_POINTS); chk32("fire sample", 32'h2, rdata);
		chk32("sample count", 32'h2, nsamp);
		chk32("last bin", 32'h1, {18'h0, last_bin});
		chk1("irq masked", 1'b0, irq);
		wr(`SBSC_OFF_IRQ_MSK, 32'h1);
		@(negedge mclk);
		chk1("irq on", 1'b1, irq);
		wr(`SBSC_OFF_IRQ_ST, 32'h1);
		@(negedge mclk);
		chk1("irq cleared", 1'b0, irq);
		rd(12'h020); chk1("unmapped", 1'b1, rerr);
		$display("test trigger done");
		wr(`SBSC_OFF_CMD, 32'h1);
		rd(`SBSC_OFF_STATUS); chk32("start run", {30'h0, SBSC_RUN}, rdata);
		wr(`SBSC_OFF_CMD, 32'h2);
		wr(`SBSC_OFF_CMD, 32'h2);
		rd(`SBSC_OFF_STATUS); chk32("hold twice", {30'h0, SBSC_PAUSE}, rdata);
		wr(`SBSC_OFF_CMD, 32'h1);
		rd(`SBSC_OFF_STATUS); chk32("resume", {30'h0, SBSC_RUN}, rdata);
		wr(`SBSC_OFF_CMD, 32'h4);
		@(negedge mclk);
		chk1("clear pulse", 1'b1, clr_seen);
		rd(`SBSC_OFF_STATUS); chk32("clear mode", {30'h0, SBSC_IDLE}, rdata);
		rd(`SBSC_OFF_POINTS); chk32("clear points", 32'h0, rdata);
		chk1("alarm", 1'b0, alarm);
		wr(`SBSC_OFF_CTRL, 32'h0E);
		sbsc_host_model_inst.trig();
		rd(`SBSC_OFF_STATUS); chk32("unarmed", {30'h0, SBSC_IDLE}, rdata);
		$display("test commands done");
		summarize();
	end
endmodule // sample_buffer_scan_control_tb
`default_nettype wire
